// File: shared/xcvr_consts.svh
// Register offsets, field positions, reset values and frame counts of the transceiver bank.
// Assumes inclusion by bare name from any file that decodes or builds register contents.
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses (three-bit address field)
// ----------------------------------------------------------------
`define ADDR_FAULT_LATCH 3'h0
`define ADDR_LIVE_STATUS 3'h1
`define ADDR_OPTIONS 3'h2
`define ADDR_CURR_LIMIT 3'h3
`define ADDR_LINE_CFG 3'h4
`define ADDR_AUX_CFG 3'h5

// ----------------------------------------------------------------
// Fault latch bit positions
// ----------------------------------------------------------------
`define LATCH_SHUTDOWN 7
`define LATCH_WAKEUP 6
`define LATCH_AUX_FAULT 5
`define LATCH_LINE_FAULT 4
`define LATCH_SUPPLY_WARN 3
`define LATCH_SUPPLY_UNDER 2
`define LATCH_UNUSED 1
`define LATCH_OVERHEAT_WARN 0

// ----------------------------------------------------------------
// Command byte layout and frame counts
// ----------------------------------------------------------------
`define CMD_WRITE_BIT 7
`define CMD_ADDR_MSB 2
`define FRAME_LAST_BIT 4'h7

// ----------------------------------------------------------------
// Reset values and the used-bit mask of the aux config
// ----------------------------------------------------------------
`define RST_FAULT_LATCH 8'h00
`define RST_OPTIONS 8'h00
`define RST_CURR_LIMIT 8'h00
`define RST_LINE_CFG 8'h00
`define RST_AUX_CFG 8'h00
`define AUX_CFG_USED_MASK 8'h7F

`endif

// File: shared/xcvr_pkg.sv
// Types shared by the transceiver register bank and its pin synchroniser.
// Assumes field order matches the bit maps kept in xcvr_consts.svh, msb first.
package xcvr_pkg;

  // ----------------------------------------------------------------
  // Live conditions, laid out exactly as the live status register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overheat_shutdown_now;
    logic aux_in_level;
    logic aux_out_fault_now;
    logic line_fault_now;
    logic supply_warn_now;
    logic supply_under_now;
    logic line_level;
    logic overheat_warn_now;
  } cond_t;

  // ----------------------------------------------------------------
  // Asynchronous inputs: pins and analog detector outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spi_mode_pin;
    logic link_share_select;
    logic shared_in_pin;
    logic shared_clock_pin;
    logic shared_select_pin;
    logic line_tx_in;
    logic line_drive_enable;
    logic wakeup_detect;
    cond_t cond;
  } pin_in_t;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic soft_reset;
    logic wakeup_irq_off;
    logic low_reg_off;
    logic pin_share_on;
    logic supply_warn_on;
    logic line_glitch_filter;
    logic indicator_b;
    logic indicator_a;
  } options_t;

  typedef struct packed {
    logic limit_sel_hi;
    logic limit_sel_lo;
    logic limit_off;
    logic blank_sel_hi;
    logic blank_sel_lo;
    logic retry_time_hi;
    logic retry_time_lo;
    logic retry_on;
  } curr_limit_t;

  typedef struct packed {
    logic line_rx_off;
    logic line_weak_pulldown;
    logic line_weak_pullup;
    logic line_aux_parallel;
    logic line_lowside_only;
    logic line_pushpull;
    logic line_out_level;
    logic line_driver_off;
  } line_cfg_t;

  typedef struct packed {
    logic unused;
    logic aux_weak_pulldown;
    logic aux_weak_pullup;
    logic aux_extra_option;
    logic aux_lowside_only;
    logic aux_pushpull;
    logic aux_out_level;
    logic aux_driver_off;
  } aux_cfg_t;

  // Levels taken from the shared pins in pin-control mode.
  typedef struct packed {
    logic high_current;
    logic lowside_only;
    logic pushpull;
  } strap_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD = 2'b01,
    SPI_DATA = 2'b10,
    SPI_DONE = 2'b11
  } spi_phase_t;

  typedef struct packed {
    pin_in_t stage1;
    pin_in_t stage2;
  } sync_state_t;

  typedef struct packed {
    spi_phase_t phase;
    logic sclk_prev;
    logic [3:0] bit_cnt;
    logic [7:0] in_shift;
    logic [2:0] addr;
    logic write;
    logic [7:0] out_shift;
    cond_t cond_prev;
    logic wake_prev;
    logic [7:0] latch;
    options_t opt;
    curr_limit_t curr;
    line_cfg_t line_cfg;
    aux_cfg_t aux_cfg;
    logic alert_pin_n;
    logic shared_out_pin;
    logic line_tx_data;
    logic line_tx_en;
    logic line_rx_out;
    strap_t strap;
  } bank_state_t;

endpackage

// File: hw/pin_sync.sv
// Two-stage synchroniser for every asynchronous pin and detector input of the bank.
// Assumes the inputs are plain levels; nothing but the second stage reads the first.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire xcvr_pkg::pin_in_t raw,
  output var xcvr_pkg::pin_in_t synced
);

  xcvr_pkg::sync_state_t state;
  xcvr_pkg::sync_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.stage1 = raw;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign synced = state.stage2;

endmodule

`default_nettype wire

// File: hw/transceiver_regs_irq_mux.sv
// Register bank of a sensor-line transceiver: SPI slave, fault latch, alert output, pin sharing.
// Assumes all pins and detector levels are asynchronous to mclk and SPI runs far below mclk.
//
// How it works
// [R1] Six 8-bit registers at 00h-05h; latch and status read-only, rest read/write.
// [R2] Fault latch bits: shutdown, wake-up, aux fault, line fault, warn, under, -, overheat.
// [R3] Status at 01h mirrors live shutdown, aux input, faults, supply, line level, warning.
// [R4] Options at 02h: soft reset, wake-up off, regulator off, sharing, warn, filter, lamps.
// [R5] Current limit at 03h: limit select, limit off, blanking, retry time, retry enable.
// [R6] Line config at 04h: receiver off, pulls, parallel, low side, push-pull, level, off.
// [R7] Aux config at 05h: bit 7 unused, pulls, option, low side, push-pull, level, off.
// [R8] Fault latch resets to zero so the alert output starts released.
// [R9] In serial-port mode the alert output is low whenever any fault latch bit is one.
// [R10] Latch bits stay set after their condition goes away.
// [R11] Reading the fault latch clears all its bits and releases alert.
// [R12] Only a new rising condition sets a bit again after a clearing read.
// [R13] Shutdown entry sets latch bit 7; live shutdown readable in status.
// [R14] A wake-up detection on the line sets latch bit 6.
// [R15] With the wake-up off option set, wake-up no longer raises the latch bit.
// [R16] Sharing on and select low: pins act as SPI, alert works, transmit pins ignored.
// [R17] Sharing on and select high: line data and enable from SPI pins, receive on out pin.
// [R18] During the UART phase select is unused, alert still works, transmit pins ignored.
// [R19] A three-bit address picks the register; 000 selects the fault latch.
// [R20] Pin-control mode: shared pins are parallel straps, no register access at all.
// [R21] Overheat warning shows in status and latch and raises alert in SPI mode.
// [R22] An event in the same cycle as a clearing read keeps its bit set.
// [R23] Unused bits read zero; writes to them or read-only registers do nothing.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module transceiver_regs_irq_mux (
  input wire logic mclk,
  input wire logic rst,
  input wire logic spi_mode_pin,
  input wire logic link_share_select,
  input wire logic shared_in_pin,
  input wire logic shared_clock_pin,
  input wire logic shared_select_pin,
  input wire logic line_tx_in,
  input wire logic line_drive_enable,
  input wire logic wakeup_detect,
  input wire xcvr_pkg::cond_t cond_in,
  output logic alert_pin_n,
  output logic shared_out_pin,
  output logic line_tx_data,
  output logic line_tx_en,
  output logic line_rx_out,
  output var xcvr_pkg::options_t options,
  output var xcvr_pkg::curr_limit_t curr_limit,
  output var xcvr_pkg::line_cfg_t line_cfg,
  output var xcvr_pkg::aux_cfg_t aux_cfg,
  output var xcvr_pkg::strap_t strap
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  xcvr_pkg::pin_in_t raw;
  xcvr_pkg::pin_in_t pins;

  always_comb begin
    raw.spi_mode_pin = spi_mode_pin;
    raw.link_share_select = link_share_select;
    raw.shared_in_pin = shared_in_pin;
    raw.shared_clock_pin = shared_clock_pin;
    raw.shared_select_pin = shared_select_pin;
    raw.line_tx_in = line_tx_in;
    raw.line_drive_enable = line_drive_enable;
    raw.wakeup_detect = wakeup_detect;
    raw.cond = cond_in;
  end

  pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .raw(raw),
    .synced(pins)
  );

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  xcvr_pkg::bank_state_t state;
  xcvr_pkg::bank_state_t next_state;

  // Register read mux; unmapped addresses read zero.
  function automatic logic [7:0] read_reg(input xcvr_pkg::bank_state_t s,
                                          input xcvr_pkg::cond_t c,
                                          input logic [2:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a) // [R19]
      `ADDR_FAULT_LATCH: d = s.latch; // [R1]
      `ADDR_LIVE_STATUS: d = c; // [R3] [R13] [R21]
      `ADDR_OPTIONS: d = s.opt;
      `ADDR_CURR_LIMIT: d = s.curr;
      `ADDR_LINE_CFG: d = s.line_cfg;
      `ADDR_AUX_CFG: d = s.aux_cfg & `AUX_CFG_USED_MASK; // [R7] [R23]
      default: d = 8'h00; // [R23]
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  logic spi_mode;
  logic shared_mode;
  logic select_low;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] shifted;
  logic [7:0] events;
  logic clear_latch;
  logic [7:0] write_val;

  always_comb begin
    next_state = state;
    spi_mode = pins.spi_mode_pin;
    shared_mode = spi_mode && state.opt.pin_share_on;
    select_low = !pins.shared_select_pin;
    sclk_rise = pins.shared_clock_pin && !state.sclk_prev;
    sclk_fall = !pins.shared_clock_pin && state.sclk_prev;
    shifted = {state.in_shift[6:0], pins.shared_in_pin};
    clear_latch = 1'b0;
    write_val = 8'h00;
    next_state.sclk_prev = pins.shared_clock_pin;

    // SPI frame: command byte (write flag, address), then data byte.
    // A frame needs serial-port mode and a low select; pin-control mode never accesses.
    if (!spi_mode || !select_low) begin // [R20]
      next_state.phase = xcvr_pkg::SPI_IDLE;
      next_state.bit_cnt = 4'h0;
      next_state.out_shift = 8'h00;
    end else begin
      case (state.phase)
        xcvr_pkg::SPI_IDLE: begin
          next_state.phase = xcvr_pkg::SPI_CMD;
          next_state.bit_cnt = 4'h0;
          next_state.out_shift = 8'h00;
          // A clock rising together with the select still counts as the first bit.
          if (sclk_rise) begin
            next_state.in_shift = shifted;
            next_state.bit_cnt = 4'h1;
          end
        end
        xcvr_pkg::SPI_CMD: begin
          if (sclk_rise) begin
            next_state.in_shift = shifted;
            next_state.bit_cnt = state.bit_cnt + 4'h1;
            if (state.bit_cnt == `FRAME_LAST_BIT) begin
              next_state.write = shifted[`CMD_WRITE_BIT];
              next_state.addr = shifted[`CMD_ADDR_MSB:0]; // [R19]
              next_state.bit_cnt = 4'h0;
              next_state.phase = xcvr_pkg::SPI_DATA;
              if (!shifted[`CMD_WRITE_BIT]) begin
                next_state.out_shift = read_reg(state, pins.cond, shifted[`CMD_ADDR_MSB:0]);
                clear_latch = (shifted[`CMD_ADDR_MSB:0] == `ADDR_FAULT_LATCH); // [R11]
              end
            end
          end
        end
        xcvr_pkg::SPI_DATA: begin
          // Bit 7 must still stand at the first data rise, so shifting waits for that rise.
          if (sclk_fall && state.bit_cnt != 4'h0) begin
            next_state.out_shift = {state.out_shift[6:0], 1'b0};
          end
          if (sclk_rise) begin
            next_state.in_shift = shifted;
            next_state.bit_cnt = state.bit_cnt + 4'h1;
            if (state.bit_cnt == `FRAME_LAST_BIT) begin
              next_state.phase = xcvr_pkg::SPI_DONE;
              if (state.write) begin
                write_val = shifted;
                case (state.addr) // [R1] [R19]
                  `ADDR_OPTIONS: next_state.opt = write_val; // [R4]
                  `ADDR_CURR_LIMIT: next_state.curr = write_val; // [R5]
                  `ADDR_LINE_CFG: next_state.line_cfg = write_val; // [R6]
                  `ADDR_AUX_CFG: next_state.aux_cfg = write_val & `AUX_CFG_USED_MASK; // [R7]
                  default: next_state.opt = state.opt; // [R23]
                endcase
              end
            end
          end
        end
        xcvr_pkg::SPI_DONE: begin
          // Surplus clocks are ignored until the select rises.
          next_state.out_shift = 8'h00;
        end
        default: begin
          next_state.phase = xcvr_pkg::SPI_IDLE;
        end
      endcase
    end

    // Soft reset returns every writable register to its reset value and self-clears.
    if (next_state.opt.soft_reset) begin // [R4]
      next_state.opt = `RST_OPTIONS;
      next_state.curr = `RST_CURR_LIMIT;
      next_state.line_cfg = `RST_LINE_CFG;
      next_state.aux_cfg = `RST_AUX_CFG;
    end

    // Events are rising edges, so a condition still present after a clearing read
    // does not set its bit again.
    next_state.cond_prev = pins.cond;
    next_state.wake_prev = pins.wakeup_detect;
    events = 8'h00;
    events[`LATCH_SHUTDOWN] = pins.cond.overheat_shutdown_now &&
                              !state.cond_prev.overheat_shutdown_now; // [R13] [R12]
    events[`LATCH_WAKEUP] = pins.wakeup_detect && !state.wake_prev &&
                            !state.opt.wakeup_irq_off; // [R14] [R15]
    events[`LATCH_AUX_FAULT] = pins.cond.aux_out_fault_now &&
                               !state.cond_prev.aux_out_fault_now; // [R2]
    events[`LATCH_LINE_FAULT] = pins.cond.line_fault_now &&
                                !state.cond_prev.line_fault_now; // [R2]
    events[`LATCH_SUPPLY_WARN] = pins.cond.supply_warn_now &&
                                 !state.cond_prev.supply_warn_now; // [R2]
    events[`LATCH_SUPPLY_UNDER] = pins.cond.supply_under_now &&
                                  !state.cond_prev.supply_under_now; // [R2]
    events[`LATCH_UNUSED] = 1'b0; // [R23]
    events[`LATCH_OVERHEAT_WARN] = pins.cond.overheat_warn_now &&
                                   !state.cond_prev.overheat_warn_now; // [R21]
    if (!spi_mode) begin
      events = 8'h00; // [R20]
    end

    // Sticky latch; a new event wins over a clear in the same cycle.
    next_state.latch = (state.latch & {8{!clear_latch}}) | events; // [R10] [R11] [R22]

    // Alert follows the latch in serial-port mode and line/aux overcurrent in pin mode.
    if (spi_mode) begin
      next_state.alert_pin_n = !(|next_state.latch); // [R9] [R16] [R18]
    end else begin
      next_state.alert_pin_n = !(pins.cond.line_fault_now || pins.cond.aux_out_fault_now);
    end

    // Pin sharing. The dedicated receive output stays active in every mode.
    next_state.line_rx_out = pins.cond.line_level; // [R16]
    next_state.strap = '0;
    if (!spi_mode) begin
      next_state.shared_out_pin = pins.cond.overheat_shutdown_now; // [R20]
      next_state.line_tx_data = pins.line_tx_in;
      next_state.line_tx_en = pins.line_drive_enable;
      next_state.strap.high_current = pins.shared_clock_pin; // [R20]
      next_state.strap.lowside_only = pins.shared_in_pin;
      next_state.strap.pushpull = pins.shared_select_pin;
    end else if (shared_mode && !select_low) begin
      next_state.shared_out_pin = pins.cond.line_level; // [R17]
      next_state.line_tx_data = pins.shared_in_pin; // [R17] [R18]
      next_state.line_tx_en = pins.shared_clock_pin; // [R17]
    end else if (shared_mode) begin
      // Dedicated transmit pins are ignored; the driver idles while SPI owns the pins.
      next_state.shared_out_pin = next_state.out_shift[7]; // [R16]
      next_state.line_tx_data = 1'b0; // [R16]
      next_state.line_tx_en = 1'b0;
    end else begin
      next_state.shared_out_pin = next_state.out_shift[7];
      next_state.line_tx_data = pins.line_tx_in;
      next_state.line_tx_en = pins.line_drive_enable;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= '0;
      state.latch <= `RST_FAULT_LATCH; // [R8]
      state.opt <= `RST_OPTIONS;
      state.curr <= `RST_CURR_LIMIT;
      state.line_cfg <= `RST_LINE_CFG;
      state.aux_cfg <= `RST_AUX_CFG;
      state.alert_pin_n <= 1'b1; // [R8]
      state.phase <= xcvr_pkg::SPI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign alert_pin_n = state.alert_pin_n;
  assign shared_out_pin = state.shared_out_pin;
  assign line_tx_data = state.line_tx_data;
  assign line_tx_en = state.line_tx_en;
  assign line_rx_out = state.line_rx_out;
  assign options = state.opt;
  assign curr_limit = state.curr;
  assign line_cfg = state.line_cfg;
  assign aux_cfg = state.aux_cfg;
  assign strap = state.strap;

endmodule

`default_nettype wire

// File: tb/mcu_model.sv
// Microcontroller stand-in: SPI master, mode 0, MSB first, plus UART and strap pin driver.
// Assumes the bench clock mclk; every pin change is made at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
  input wire logic mclk,
  input wire logic sdo,
  output logic sdi,
  output logic sclk,
  output logic sel_n
);
  initial begin
    sdi = 1'b0;
    sclk = 1'b0;
    sel_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // --------------------
  // Frames
  // --------------------
  // Six mclk per half period keeps clear of the four-cycle minimum.
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    sclk = 1'b0;
    hold(2);
    sel_n = 1'b0;
    hold(6);
    for (int i = 15; i >= 0; i--) begin
      sdi = frame[i];
      hold(6);
      sclk = 1'b1;
      // The rise reaches the design cycles later, so the pin still shows the settled bit.
      if (i < 8) rd = {rd[6:0], sdo};
      hold(6);
      sclk = 1'b0;
    end
    hold(6);
    sel_n = 1'b1;
    // A released data line must not look like a held bit.
    sdi = ~sdi;
    hold(12);
  endtask
  task automatic pins(input logic d, input logic c, input logic s);
    sdi = d;
    sclk = c;
    sel_n = s;
  endtask
endmodule
`default_nettype wire

// File: tb/xcvr_chk.sv
// Concurrent checks on the pins and register outputs of the transceiver bank.
// Assumes one clock mclk and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module xcvr_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic spi_mode_pin,
  input wire logic shared_in_pin,
  input wire logic shared_clock_pin,
  input wire logic shared_select_pin,
  input wire logic wakeup_detect,
  input wire xcvr_pkg::cond_t cond_in,
  input wire logic alert_pin_n,
  input wire logic shared_out_pin,
  input wire logic line_tx_data,
  input wire logic line_tx_en,
  input wire logic line_rx_out,
  input wire xcvr_pkg::options_t options,
  input wire xcvr_pkg::aux_cfg_t aux_cfg,
  input wire xcvr_pkg::strap_t strap
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // --------------------
  // Settling counters
  // --------------------
  // Checks wait out the two-stage synchroniser, so glitches shorter than that go unjudged.
  logic [3:0] age;
  logic [3:0] quiet;
  always_ff @(posedge mclk) begin
    if (rst) begin
      age <= 4'h0;
      quiet <= 4'h0;
    end else begin
      age <= (age == 4'hF) ? age : age + 4'h1;
      if (!(spi_mode_pin && shared_select_pin)) begin
        quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
        quiet <= quiet + 4'h1;
      end
    end
  end
  // --------------------
  // Properties
  // --------------------
  a_reset_clears: assert property (disable iff (1'b0) rst |=> alert_pin_n && options == '0)
    else $error("alert or options not cleared by reset");
  a_aux_top_zero: assert property (aux_cfg[7] == 1'b0)
    else $error("aux config bit 7 not zero");
  a_event_alert: assert property ($rose(cond_in.overheat_warn_now) && quiet > 4'h8
    |-> ##[2:6] !alert_pin_n) else $error("warning did not raise alert");
  a_alert_sticky: assert property (!alert_pin_n && quiet > 4'h8 |=> !alert_pin_n)
    else $error("alert released without a read");
  a_wake_alert: assert property ($rose(wakeup_detect) && quiet > 4'h8
    && !options.wakeup_irq_off |-> ##[2:6] !alert_pin_n)
    else $error("wake-up did not raise alert");
  a_share_tx: assert property ((options.pin_share_on && quiet > 4'h4
    && $stable(shared_in_pin)
    && $stable(shared_clock_pin))[*4] |-> line_tx_data == shared_in_pin
    && line_tx_en == shared_clock_pin) else $error("shared transmit pins not routed");
  a_share_rx: assert property ((options.pin_share_on && quiet > 4'h4
    && $stable(cond_in))[*4]
    |-> shared_out_pin == cond_in.line_level) else $error("line level not on shared out pin");
  a_spi_mute: assert property ((options.pin_share_on && spi_mode_pin && !shared_select_pin
    && $stable(options))[*4] |-> !line_tx_data && !line_tx_en)
    else $error("line driven during frame");
  a_rx_follow: assert property ((age > 4'h4 && $stable(cond_in))[*4]
    |-> line_rx_out == cond_in.line_level) else $error("receive output not line level");
  a_pin_mode: assert property ((!spi_mode_pin && age > 4'h4 && $stable(cond_in)
    && $stable({shared_in_pin, shared_clock_pin, shared_select_pin}))[*5]
    |-> alert_pin_n == !(cond_in.line_fault_now || cond_in.aux_out_fault_now)
    && strap == {shared_clock_pin, shared_in_pin, shared_select_pin}
    && shared_out_pin == cond_in.overheat_shutdown_now) else $error("pin mode outputs wrong");
endmodule
bind transceiver_regs_irq_mux xcvr_chk chk (.mclk, .rst, .spi_mode_pin, .shared_in_pin,
  .shared_clock_pin, .shared_select_pin, .wakeup_detect, .cond_in, .alert_pin_n,
  .shared_out_pin, .line_tx_data, .line_tx_en, .line_rx_out, .options, .aux_cfg, .strap);
`default_nettype wire

// File: tb/transceiver_regs_irq_mux_bench.sv
// Self-checking bench of the transceiver register bank, driven through the SPI model.
// Assumes the design, package, model and checker files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module transceiver_regs_irq_mux_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic spi_mode_pin, link_share_select, line_tx_in, line_drive_enable, wakeup_detect;
  logic sdi, sclk, sel_n, sdo, alert_n, tx_d, tx_en, rx_out;
  xcvr_pkg::cond_t cond;
  xcvr_pkg::options_t options;
  xcvr_pkg::curr_limit_t curr_limit;
  xcvr_pkg::line_cfg_t line_cfg;
  xcvr_pkg::aux_cfg_t aux_cfg;
  xcvr_pkg::strap_t strap;
  logic [7:0] rd, wd;
  int err_count = 0;
  int total_checks = 0;
  always #2.5 mclk = ~mclk;
  mcu_model mcu (.mclk(mclk), .sdo(sdo), .sdi(sdi), .sclk(sclk), .sel_n(sel_n));
  transceiver_regs_irq_mux dut (.mclk(mclk), .rst(rst), .spi_mode_pin(spi_mode_pin),
    .link_share_select(link_share_select), .shared_in_pin(sdi), .shared_clock_pin(sclk),
    .shared_select_pin(sel_n), .line_tx_in(line_tx_in), .line_drive_enable(line_drive_enable),
    .wakeup_detect(wakeup_detect), .cond_in(cond), .alert_pin_n(alert_n), .shared_out_pin(sdo),
    .line_tx_data(tx_d), .line_tx_en(tx_en), .line_rx_out(rx_out), .options(options),
    .curr_limit(curr_limit), .line_cfg(line_cfg), .aux_cfg(aux_cfg), .strap(strap));
  // --------------------
  // Helpers
  // --------------------
  function automatic logic [7:0] latch_exp(input logic [7:0] c);
    return c & 8'hBD;
  endfunction
  function automatic logic [4:0] pin_exp(input logic [7:0] w);
    return {w[1], w[0], w[2], w[7], ~(w[4] | w[5])};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] junk;
    mcu.xfer({5'h10, a, d}, junk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    mcu.xfer({5'h00, a, 8'h00}, rd);
    `CHECK(rd, exp)
  endtask
  task automatic wake();
    wakeup_detect = 1'b1;
    cyc(8);
    wakeup_detect = 1'b0;
    cyc(4);
  endtask
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    wd = 8'($urandom(9840));
    {spi_mode_pin, link_share_select, line_tx_in, line_drive_enable, wakeup_detect} = 5'h10;
    cond = '0;
    cyc(20);
    rst = 1'b0;
    cyc(4);
    `CHECK({alert_n, options, curr_limit, line_cfg, aux_cfg}, 33'h100000000)
    rchk(3'h0, 8'h00);
    for (int i = 2; i < 6; i++) begin
      wd = 8'($urandom()) & ((i == 2) ? 8'h6F : 8'hFF);
      wr(i[2:0], wd);
      rchk(i[2:0], (i == 5) ? (wd & 8'h7F) : wd);
    end
    wr(3'h2, 8'h80);
    `CHECK({options, curr_limit, line_cfg, aux_cfg}, 32'h00000000)
    wr(3'h7, 8'hFF);
    `CHECK(curr_limit, 8'h00)
    cond = 8'($urandom()) | 8'h01;
    cyc(8);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    rchk(3'h1, cond);
    rchk(3'h0, latch_exp(cond));
    rchk(3'h0, 8'h00);
    cond = '0;
    cyc(8);
    for (int i = 0; i < 8; i++) begin
      cond[i] = 1'b1;
      cyc(8);
      cond[i] = 1'b0;
      cyc(8);
      `CHECK(alert_n, ~|latch_exp(8'h01 << i))
      rchk(3'h0, latch_exp(8'h01 << i));
      `CHECK(alert_n, 1'b1)
    end
    wake();
    `CHECK(alert_n, 1'b0)
    rchk(3'h0, 8'h40);
    wr(3'h2, 8'h40);
    wake();
    `CHECK(alert_n, 1'b1)
    rchk(3'h0, 8'h00);
    {line_tx_in, line_drive_enable} = 2'b10;
    cyc(8);
    `CHECK({tx_d, tx_en}, 2'b10)
    wr(3'h2, 8'h10);
    for (int i = 0; i < 6; i++) begin
      wd = 8'($urandom());
      mcu.pins(wd[0], wd[1], 1'b1);
      {line_tx_in, line_drive_enable, cond.line_level, link_share_select} = wd[5:2];
      cyc(8);
      `CHECK({tx_d, tx_en, sdo, rx_out}, {wd[0], wd[1], wd[3], wd[3]})
    end
    mcu.pins(1'b0, 1'b0, 1'b1);
    cond.overheat_warn_now = 1'b1;
    cyc(8);
    `CHECK(alert_n, 1'b0)
    rchk(3'h0, 8'h01);
    wr(3'h3, 8'h5A);
    spi_mode_pin = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wd = 8'($urandom());
      cond = wd;
      mcu.pins(wd[0], wd[1], wd[2]);
      cyc(8);
      `CHECK({strap, sdo, alert_n}, pin_exp(wd))
    end
    mcu.pins(1'b0, 1'b0, 1'b1);
    wr(3'h3, 8'hFF);
    `CHECK(curr_limit, 8'h5A)
    cond = '0;
    cyc(8);
    spi_mode_pin = 1'b1;
    cyc(8);
    rchk(3'h0, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
